// ### design/mfp_pkg.sv
/*
 * mfp_pkg: shared constants and carriers for the multifunction pin and
 * configuration register block.
 * assumes: one 40 MHz clock domain, register access by a serial-bus core
 * that presents one decoded word access per cycle.
 */
package mfp_pkg;
    // register offsets (8-bit register address space)
    localparam logic [7:0] MFP_OFS_PIN_SETUP = 8'h24;
    localparam logic [7:0] MFP_OFS_PROTECT_SETUP = 8'h25;
    localparam logic [7:0] MFP_OFS_HOST_SETUP = 8'h26;
    localparam logic [7:0] MFP_OFS_MEM_POINTER = 8'h2b;
    localparam logic [7:0] MFP_OFS_MEM_WORD = 8'h2c;
    localparam logic [7:0] MFP_OFS_ALL_CODE = 8'h50;

    // reset values
    localparam logic [15:0] MFP_RST_PIN_SETUP = 16'h0000;
    localparam logic [15:0] MFP_RST_PROTECT_SETUP = 16'h0000;
    localparam logic [15:0] MFP_RST_HOST_SETUP = 16'h0000;
    localparam logic [7:0] MFP_RST_MEM_POINTER = 8'h00;
    localparam logic [15:0] MFP_RST_ALL_CODE = 16'h0000;

    // field positions in pin_function_setup
    localparam int MFP_BIT_FILTER_EN = 15;
    localparam int MFP_BIT_OUT_EN = 13;
    localparam int MFP_POS_OUT_SEL = 9;
    localparam int MFP_POS_CH_MASK = 5;
    localparam int MFP_POS_IN_FUNC = 1;
    localparam int MFP_BIT_IN_EN = 0;
    // writable bits per register
    localparam logic [15:0] MFP_MASK_PIN_SETUP = 16'hbfff;
    localparam logic [15:0] MFP_MASK_PROTECT_SETUP = 16'hffe0;
    localparam logic [15:0] MFP_MASK_HOST_SETUP = 16'h1105;
    // protect selector and serial-out bits
    localparam int MFP_POS_PROTECT_SEL = 8;
    localparam int MFP_BIT_FAST_SO = 2;
    localparam int MFP_BIT_SO_EN = 0;
    localparam int MFP_POS_CODE = 4;

    // output status selector codes
    localparam logic [3:0] MFP_OSEL_CONV_VALID = 4'h0;
    localparam logic [3:0] MFP_OSEL_NV_BUSY = 4'h1;
    localparam logic [3:0] MFP_OSEL_CH2_BUSY = 4'h4;
    localparam logic [3:0] MFP_OSEL_CH0_BUSY = 4'h6;
    localparam logic [3:0] MFP_OSEL_CH1_BUSY = 4'h7;
    localparam logic [3:0] MFP_OSEL_WINDOW = 4'hb;

    // input function codes
    localparam logic [3:0] MFP_IFN_FAULT_DUMP = 4'h2;
    localparam logic [3:0] MFP_IFN_POWER = 4'h4;
    localparam logic [3:0] MFP_IFN_CLEAR = 4'h7;
    localparam logic [3:0] MFP_IFN_LOAD = 4'h8;
    localparam logic [3:0] MFP_IFN_WAVE = 4'h9;
    localparam logic [3:0] MFP_IFN_MARGIN = 4'ha;
    localparam logic [3:0] MFP_IFN_RESET = 4'hb;
    localparam logic [3:0] MFP_IFN_NV_PROTECT = 4'hc;
    localparam logic [3:0] MFP_IFN_REG_LOCK = 4'hd;

    // glitch filter: input must be stable this many cycles
    localparam int MFP_FILTER_CYCLES = 4;

    // protect behaviour selector
    typedef enum logic [1:0] {
        MFP_PROT_HIZ, MFP_PROT_NV_CODE, MFP_PROT_MARGIN_LO, MFP_PROT_MARGIN_HI
    } mfp_protect_t;

    // status bits that may be routed to the pin
    typedef struct packed {
        logic conversion_result_valid;
        logic nonvolatile_busy;
        logic ch2_busy;
        logic ch0_busy;
        logic ch1_busy;
        logic window_compare_result;
    } mfp_status_t;

    // per-channel event strobes, index 0..2 = channel 0..2
    typedef struct packed {
        logic [2:0] power_down;
        logic [2:0] power_up;
        logic [2:0] load;
        logic [2:0] wave_stop;
        logic [2:0] wave_start;
        logic [2:0] margin_lo;
        logic [2:0] margin_hi;
    } mfp_chan_evt_t;

    // global pin actions
    typedef struct packed {
        logic fault_dump;
        logic clear_outputs;
        logic reset_req;
        logic nv_prog_allow;
        logic reg_write_allow;
    } mfp_global_t;

    // register access from the serial-bus core
    typedef struct packed {
        logic wr;
        logic rd;
        logic from_i2c;
        logic [7:0] addr;
        logic [15:0] wdata;
    } mfp_req_t;
endpackage

// ### design/mfp_scratch_mem.sv
/*
 * mfp_scratch_mem: 256 x 16 scratch word store, registered read data.
 * assumes: single clock, one access per cycle, read data one cycle later.
 */
module mfp_scratch_mem
    import mfp_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [2**AW];

    // write port
    always_ff @(posedge i_ref_clk) begin
        if (i_ce && i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // registered read port
    always_ff @(posedge i_ref_clk) begin
        if (i_ce && i_re) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// ### design/mfp_regs.sv
/*
 * mfp_regs: multifunction pin control and configuration registers.
 * assumes: a serial-bus core delivers decoded word accesses; the pin
 * arrives asynchronously; all strobe outputs go to logic on i_ref_clk.
 */
module mfp_regs
    import mfp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire mfp_req_t i_req,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_unlock_field_wr,
    input wire logic i_reset_field_wr,
    input wire mfp_status_t i_status,
    input wire logic [2:0] i_sync_update_en,
    input wire logic [2:0] i_channel_broadcast_enable,
    input wire logic i_serial_data,
    input wire logic i_serial_active,
    input wire logic i_multifunction_pin_in,
    output logic o_multifunction_pin_out,
    output logic o_multifunction_pin_oe,
    output mfp_chan_evt_t o_chan_evt,
    output mfp_global_t o_global,
    output mfp_protect_t o_protect_sel,
    output logic o_fast_serial_out_enable,
    output logic [2:0] o_code_load,
    output logic [15:0] o_shared_channel_code
);
    logic [15:0] pin_setup_q;
    logic [15:0] protect_setup_q;
    logic [15:0] host_setup_q;
    logic [7:0] mem_ptr_q;
    logic [15:0] all_code_q;
    logic [15:0] mem_rdata;
    logic sync1_q, sync2_q, filt_q, prev_q;
    logic [2:0] stab_cnt_q;
    logic clear_q, reset_q, nv_allow_q, reg_allow_q;
    logic rd_mem_q;
    logic [15:0] rdata_d;
    logic pin_in, rise, fall, wr_ok;
    logic [3:0] in_func;
    logic [2:0] chan_sel;
    logic out_bit;

    // maps mask bits to channel order 0,1,2
    function automatic logic [2:0] chan_of(input logic [3:0] m);
        return {m[0], m[3], m[2]};
    endfunction

    // writes pass unless the pin lock is active and neither an unlock-field write nor an I2C reset-field write is flagged
    assign wr_ok = i_req.wr && (reg_allow_q || i_unlock_field_wr ||
                   (i_reset_field_wr && i_req.from_i2c));

    // configuration registers
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_setup_q <= MFP_RST_PIN_SETUP;
            protect_setup_q <= MFP_RST_PROTECT_SETUP;
            host_setup_q <= MFP_RST_HOST_SETUP;
            all_code_q <= MFP_RST_ALL_CODE;
        end else if (i_ce && wr_ok) begin
            case (i_req.addr)
                MFP_OFS_PIN_SETUP: pin_setup_q <= i_req.wdata & MFP_MASK_PIN_SETUP;
                MFP_OFS_PROTECT_SETUP: begin
                    protect_setup_q <= i_req.wdata & MFP_MASK_PROTECT_SETUP;
                end
                MFP_OFS_HOST_SETUP: host_setup_q <= i_req.wdata & MFP_MASK_HOST_SETUP;
                MFP_OFS_ALL_CODE: all_code_q <= i_req.wdata;
                default: ;
            endcase
        end
    end

    // memory pointer: host load, increment after each data write
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_ptr_q <= MFP_RST_MEM_POINTER;
        end else if (i_ce && wr_ok) begin
            if (i_req.addr == MFP_OFS_MEM_POINTER) begin
                mem_ptr_q <= i_req.wdata[7:0];
            end else if (i_req.addr == MFP_OFS_MEM_WORD) begin
                mem_ptr_q <= mem_ptr_q + 8'h01;
            end
        end
    end

    // scratch memory at the pointer
    mfp_scratch_mem #(.AW(8), .DW(16)) u_mem (
        .i_ref_clk(i_ref_clk),
        .i_ce(i_ce),
        .i_we(wr_ok && i_req.addr == MFP_OFS_MEM_WORD),
        .i_re(i_req.rd && i_req.addr == MFP_OFS_MEM_WORD),
        .i_addr(mem_ptr_q),
        .i_wdata(i_req.wdata),
        .o_rdata(mem_rdata)
    );

    // read mux, unmapped reads as zero
    always_comb begin
        rdata_d = 16'h0000;
        case (i_req.addr)
            MFP_OFS_PIN_SETUP: rdata_d = pin_setup_q;
            MFP_OFS_PROTECT_SETUP: rdata_d = protect_setup_q;
            MFP_OFS_HOST_SETUP: rdata_d = host_setup_q;
            MFP_OFS_MEM_POINTER: rdata_d = {8'h00, mem_ptr_q};
            MFP_OFS_ALL_CODE: rdata_d = all_code_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    // read data registered, memory word one cycle later via its register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
            rd_mem_q <= 1'b0;
        end else if (i_ce) begin
            rd_mem_q <= i_req.rd && i_req.addr == MFP_OFS_MEM_WORD;
            if (rd_mem_q) begin
                o_rdata <= mem_rdata;
            end else if (i_req.rd && i_req.addr != MFP_OFS_MEM_WORD) begin
                o_rdata <= rdata_d;
            end
        end
    end
    assign o_rvalid = rd_mem_q || (i_req.rd && i_req.addr != MFP_OFS_MEM_WORD);

    // two-stage pin synchroniser
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (i_ce) begin
            sync1_q <= i_multifunction_pin_in;
            sync2_q <= sync1_q;
        end
    end

    // glitch filter: accept a level stable for the filter window
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            filt_q <= 1'b1;
            stab_cnt_q <= 3'h0;
        end else if (i_ce) begin
            if (sync2_q == filt_q) begin
                stab_cnt_q <= 3'h0;
            end else if (stab_cnt_q == 3'(MFP_FILTER_CYCLES - 1)) begin
                filt_q <= sync2_q;
                stab_cnt_q <= 3'h0;
            end else begin
                stab_cnt_q <= stab_cnt_q + 3'h1;
            end
        end
    end

    assign pin_in = pin_setup_q[MFP_BIT_FILTER_EN] ? filt_q : sync2_q;

    // edge detector on the chosen level
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'b1;
        end else if (i_ce) begin
            prev_q <= pin_in;
        end
    end

    assign rise = i_ce && pin_setup_q[MFP_BIT_IN_EN] && pin_in && !prev_q;
    assign fall = i_ce && pin_setup_q[MFP_BIT_IN_EN] && !pin_in && prev_q;
    assign in_func = pin_setup_q[MFP_POS_IN_FUNC +: 4];
    assign chan_sel = chan_of(pin_setup_q[MFP_POS_CH_MASK +: 4]);

    // channel events
    always_comb begin
        o_chan_evt = '0;
        case (in_func)
            MFP_IFN_POWER: begin
                o_chan_evt.power_down = {3{fall}} & chan_sel;
                o_chan_evt.power_up = {3{rise}} & chan_sel;
            end
            MFP_IFN_LOAD: o_chan_evt.load = {3{fall}} & chan_sel & i_sync_update_en;
            MFP_IFN_WAVE: begin
                o_chan_evt.wave_stop = {3{fall}} & chan_sel;
                o_chan_evt.wave_start = {3{rise}} & chan_sel;
            end
            MFP_IFN_MARGIN: begin
                o_chan_evt.margin_lo = {3{fall}} & chan_sel;
                o_chan_evt.margin_hi = {3{rise}} & chan_sel;
            end
            default: ;
        endcase
    end

    // global pin-held states
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reset_q <= 1'b0;
            nv_allow_q <= 1'b1;
            reg_allow_q <= 1'b1;
        end else if (fall || rise) begin
            case (in_func)
                MFP_IFN_RESET: reset_q <= fall;
                MFP_IFN_NV_PROTECT: nv_allow_q <= fall;
                MFP_IFN_REG_LOCK: reg_allow_q <= fall;
                default: ;
            endcase
        end
    end

    // clear held while pin low
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clear_q <= 1'b0;
        end else if (i_ce) begin
            clear_q <= pin_setup_q[MFP_BIT_IN_EN] && in_func == MFP_IFN_CLEAR
                       && !pin_in;
        end
    end

    always_comb begin
        o_global.fault_dump = fall && in_func == MFP_IFN_FAULT_DUMP;
        o_global.clear_outputs = clear_q;
        o_global.reset_req = reset_q;
        o_global.nv_prog_allow = nv_allow_q;
        o_global.reg_write_allow = reg_allow_q;
    end

    // status routing
    always_comb begin
        case (pin_setup_q[MFP_POS_OUT_SEL +: 4])
            MFP_OSEL_CONV_VALID: out_bit = i_status.conversion_result_valid;
            MFP_OSEL_NV_BUSY: out_bit = i_status.nonvolatile_busy;
            MFP_OSEL_CH2_BUSY: out_bit = i_status.ch2_busy;
            MFP_OSEL_CH0_BUSY: out_bit = i_status.ch0_busy;
            MFP_OSEL_CH1_BUSY: out_bit = i_status.ch1_busy;
            MFP_OSEL_WINDOW: out_bit = i_status.window_compare_result;
            default: out_bit = 1'b0;
        endcase
    end

    // pin driver: serial read data takes priority while a read is active
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_multifunction_pin_out <= 1'b0;
            o_multifunction_pin_oe <= 1'b0;
        end else if (i_ce) begin
            if (host_setup_q[MFP_BIT_SO_EN] && i_serial_active) begin
                o_multifunction_pin_out <= i_serial_data;
                o_multifunction_pin_oe <= 1'b1;
            end else begin
                o_multifunction_pin_out <= out_bit;
                o_multifunction_pin_oe <= pin_setup_q[MFP_BIT_OUT_EN];
            end
        end
    end

    assign o_protect_sel = mfp_protect_t'(protect_setup_q[MFP_POS_PROTECT_SEL +: 2]);
    assign o_fast_serial_out_enable = host_setup_q[MFP_BIT_FAST_SO];
    assign o_shared_channel_code = all_code_q;
    // one-cycle load of the shared code into enabled channels
    assign o_code_load = {3{i_ce && wr_ok && i_req.addr == MFP_OFS_ALL_CODE}}
                         & i_channel_broadcast_enable;

    a_sync_chain: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && $past(i_ce) |-> sync2_q == $past(sync1_q))
        else $error("pin sync chain broken");
    a_oe_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && !host_setup_q[MFP_BIT_SO_EN] && !pin_setup_q[MFP_BIT_OUT_EN] ##1 1'b1
        |-> !o_multifunction_pin_oe)
        else $error("pin driven without output enable");
    a_ptr_incr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && wr_ok && i_req.addr == MFP_OFS_MEM_WORD |=> mem_ptr_q == $past(mem_ptr_q) + 8'h01)
        else $error("pointer did not increment");
    a_fault_edge: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_global.fault_dump |-> !pin_in && prev_q)
        else $error("fault dump without falling edge");
    a_power_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_chan_evt.power_down & ~chan_sel) == 3'h0)
        else $error("power event on unselected channel");
    a_lock_block: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && !reg_allow_q && !i_unlock_field_wr && !i_reset_field_wr
        && i_req.addr == MFP_OFS_PROTECT_SETUP |=> $stable(protect_setup_q))
        else $error("locked write took effect");
    a_one_event: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        fall |=> !fall)
        else $error("edge gave two events");
    a_bcast_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_code_load & ~i_channel_broadcast_enable) == 3'h0)
        else $error("broadcast to disabled channel");
    a_no_input: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !pin_setup_q[MFP_BIT_IN_EN] |-> !rise && !fall)
        else $error("edge event with input disabled");

    c_power_down: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_chan_evt.power_down != 3'h0);
    c_mem_write: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_ok && i_req.addr == MFP_OFS_MEM_WORD ##2 wr_ok && i_req.addr == MFP_OFS_MEM_WORD);
    c_locked: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) !reg_allow_q);
endmodule

// ### sim/mfp_host_model.sv
/*
 * mfp_host_model: register-access host facing the pin/config block.
 * assumes: callers enter tasks 1 ns after a rising edge; reads answer
 * as the block's hand-over timing describes.
 */
module mfp_host_model
    import mfp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid,
    output mfp_req_t o_req
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus from time zero
    initial o_req = '0;

    // one write cycle, then an idle edge; callers order setup writes
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic i2c = 1'b0);
        o_req = '{wr: 1'b1, rd: 1'b0, from_i2c: i2c, addr: a, wdata: d};
        @(posedge i_ref_clk);
        #1;
        o_req.wr = 1'b0;
        @(posedge i_ref_clk);
        #1;
    endtask

    // read: valid seen in the strobe cycle or the one after, data then stands
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        logic v;
        o_req = '{wr: 1'b0, rd: 1'b1, from_i2c: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge i_ref_clk);
        v = i_rvalid;
        @(posedge i_ref_clk);
        #1;
        o_req.rd = 1'b0;
        @(negedge i_ref_clk);
        v = v || i_rvalid;
        @(posedge i_ref_clk);
        #1;
        d = (v === 1'b1) ? i_rdata : 16'hxxxx;
    endtask
endmodule

// ### sim/test_multifunction_pin_and_config_regs.sv
/*
 * test_multifunction_pin_and_config_regs: self-checking bench for mfp_regs.
 * assumes: mfp_host_model issues register accesses; pin and status
 * levels are driven here 1 ns after the rising edge.
 */
module test_multifunction_pin_and_config_regs
    import mfp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    mfp_req_t req;
    logic [15:0] rdata, code;
    logic rvalid, unl = 1'b0, rsf = 1'b0, sdata = 1'b0, sact = 1'b0, pin = 1'b1, ce = 1'b1;
    mfp_status_t status = '0;
    logic [2:0] sync_en = 3'b101, bc_en = 3'b101, cload, load_seen;
    logic pout, poe, fso, dump_seen;
    mfp_chan_evt_t evt, evt_seen;
    mfp_global_t glb;
    mfp_protect_t psel;
    int miscompares = 0, total_checks = 0, evt_cnt;
    logic [15:0] d;
    logic [7:0] ofs[6] = '{8'h24, 8'h25, 8'h26, 8'h2b, 8'h50, 8'h30};
    logic [15:0] wmask[6] = '{16'hbfff, 16'hffe0, 16'h1105, 16'h00ff, 16'hffff, 16'h0000};
    logic [3:0] osel[6] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'hb};
    logic [3:0] gc[5] = '{MFP_IFN_FAULT_DUMP, MFP_IFN_CLEAR, MFP_IFN_RESET,
        MFP_IFN_NV_PROTECT, MFP_IFN_REG_LOCK};
    logic [4:0] gfall[5] = '{5'h03, 5'h0b, 5'h07, 5'h03, 5'h01};
    logic [4:0] grise[5] = '{5'h03, 5'h03, 5'h03, 5'h01, 5'h00};
    logic [3:0] cc[4] = '{MFP_IFN_POWER, MFP_IFN_LOAD, MFP_IFN_WAVE, MFP_IFN_MARGIN};
    logic [3:0] cm[4] = '{4'b0100, 4'b1011, 4'b1001, 4'b1110};
    logic [2:0] cx[4] = '{3'b001, 3'b100, 3'b110, 3'b011};

    // clock and reset
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
    end

    mfp_host_model u_host (.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

    mfp_regs dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_req(req),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_unlock_field_wr(unl),
        .i_reset_field_wr(rsf), .i_status(status), .i_sync_update_en(sync_en),
        .i_channel_broadcast_enable(bc_en), .i_serial_data(sdata),
        .i_serial_active(sact), .i_multifunction_pin_in(pin),
        .o_multifunction_pin_out(pout), .o_multifunction_pin_oe(poe),
        .o_chan_evt(evt), .o_global(glb), .o_protect_sel(psel),
        .o_fast_serial_out_enable(fso), .o_code_load(cload),
        .o_shared_channel_code(code)
    );

    // sticky capture of single-cycle strobes
    always @(posedge clk) begin
        evt_seen <= evt_seen | evt;
        dump_seen <= dump_seen | glb.fault_dump;
        load_seen <= load_seen | cload;
        if (evt != '0 || glb.fault_dump) evt_cnt <= evt_cnt + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic clr_seen();
        evt_seen = '0;
        dump_seen = 1'b0;
        load_seen = '0;
        evt_cnt = 0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        u_host.rd(a, d);
        check(d, exp);
    endtask

    // move the pin and let sync plus filter settle
    task automatic pin_to(input logic v);
        clr_seen();
        pin = v;
        repeat (12) @(posedge clk);
        #1;
    endtask

    function automatic mfp_chan_evt_t exp_evt(input logic [3:0] f, input logic fall,
        input logic [2:0] ch);
        mfp_chan_evt_t e;
        e = '0;
        case (f)
            MFP_IFN_POWER: if (fall) e.power_down = ch; else e.power_up = ch;
            MFP_IFN_LOAD: if (fall) e.load = ch;
            MFP_IFN_WAVE: if (fall) e.wave_stop = ch; else e.wave_start = ch;
            default: if (fall) e.margin_lo = ch; else e.margin_hi = ch;
        endcase
        return e;
    endfunction

    task automatic test_done();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end

    // main sequence
    initial begin
        clr_seen();
        @(posedge rst_n);
        @(posedge clk);
        #1;
        for (int i = 0; i < 6; i++) begin
            rchk(ofs[i], 16'h0000);
            u_host.wr(ofs[i], 16'hffff);
            rchk(ofs[i], wmask[i]);
            u_host.wr(ofs[i], 16'h0000);
        end
        for (int p = 0; p < 4; p++) begin
            u_host.wr(MFP_OFS_PROTECT_SETUP, 16'(p) << 8);
            check(psel, p);
        end
        u_host.wr(MFP_OFS_MEM_POINTER, 16'h00fe);
        u_host.wr(MFP_OFS_MEM_WORD, 16'h1234);
        u_host.wr(MFP_OFS_MEM_WORD, 16'h5678);
        rchk(MFP_OFS_MEM_POINTER, 16'h0000);
        u_host.wr(MFP_OFS_MEM_POINTER, 16'h00fe);
        rchk(MFP_OFS_MEM_WORD, 16'h1234);
        u_host.wr(MFP_OFS_MEM_POINTER, 16'h00ff);
        rchk(MFP_OFS_MEM_WORD, 16'h5678);
        clr_seen();
        u_host.wr(MFP_OFS_ALL_CODE, 16'habc0);
        @(posedge clk);
        #1;
        check(load_seen, 3'b101);
        check(code, 16'habc0);
        // clock enable low: a write must neither land nor strobe
        ce = 1'b0;
        clr_seen();
        u_host.wr(MFP_OFS_ALL_CODE, 16'h5550);
        ce = 1'b1;
        check({load_seen, code}, {3'b000, 16'habc0});
        // status routing and serial override
        for (int i = 0; i < 6; i++) begin
            u_host.wr(MFP_OFS_PIN_SETUP, 16'h2000 | (16'(osel[i]) << 9));
            status = 6'b100000 >> i;
            repeat (3) @(posedge clk);
            #1 check({poe, pout}, 2'b11);
            status = ~status;
            repeat (3) @(posedge clk);
            #1 check(pout, 1'b0);
        end
        u_host.wr(MFP_OFS_PIN_SETUP, 16'h0000);
        repeat (2) @(posedge clk);
        #1 check(poe, 1'b0);
        u_host.wr(MFP_OFS_PIN_SETUP, 16'h2000);
        u_host.wr(MFP_OFS_HOST_SETUP, 16'h0005);
        status = '1;
        sact = 1'b1;
        repeat (3) @(posedge clk);
        #1 check({fso, pout}, 2'b10);
        u_host.wr(MFP_OFS_HOST_SETUP, 16'h0004);
        repeat (3) @(posedge clk);
        #1 check(pout, 1'b1);
        sact = 1'b0;
        // global pin functions
        for (int i = 0; i < 5; i++) begin
            u_host.wr(MFP_OFS_PIN_SETUP, {11'h000, gc[i], 1'b1});
            pin_to(1'b0);
            check({glb, dump_seen}, {gfall[i], i == 0});
            pin_to(1'b1);
            check(glb, grise[i]);
        end
        u_host.wr(MFP_OFS_PROTECT_SETUP, 16'h0100);
        rchk(MFP_OFS_PROTECT_SETUP, 16'h0300);
        rsf = 1'b1;
        u_host.wr(MFP_OFS_PROTECT_SETUP, 16'h0100);
        rchk(MFP_OFS_PROTECT_SETUP, 16'h0300);
        u_host.wr(MFP_OFS_PROTECT_SETUP, 16'h0100, 1'b1);
        rsf = 1'b0;
        rchk(MFP_OFS_PROTECT_SETUP, 16'h0100);
        unl = 1'b1;
        u_host.wr(MFP_OFS_PROTECT_SETUP, 16'h0200);
        unl = 1'b0;
        rchk(MFP_OFS_PROTECT_SETUP, 16'h0200);
        pin_to(1'b0);
        check(glb.reg_write_allow, 1'b1);
        u_host.wr(MFP_OFS_PIN_SETUP, 16'h0088);
        pin_to(1'b1);
        check(evt_cnt, 0);
        u_host.wr(MFP_OFS_PIN_SETUP, 16'h009f);
        pin_to(1'b0);
        check(evt_cnt, 0);
        pin_to(1'b1);
        // channel functions
        for (int i = 0; i < 4; i++) begin
            u_host.wr(MFP_OFS_PIN_SETUP, {7'h00, cm[i], cc[i], 1'b1});
            pin_to(1'b0);
            check(evt_seen, exp_evt(cc[i], 1'b1, cx[i]));
            check(evt_cnt, 1);
            pin_to(1'b1);
            check(evt_seen, exp_evt(cc[i], 1'b0, cx[i]));
        end
        // short glitch: filtered away, passed when unfiltered
        for (int f = 1; f >= 0; f--) begin
            u_host.wr(MFP_OFS_PIN_SETUP, {f[0], 15'h0089});
            clr_seen();
            pin = 1'b0;
            repeat (2) @(posedge clk);
            #1 pin = 1'b1;
            repeat (12) @(posedge clk);
            #1 check(evt_cnt, f ? 0 : 2);
        end
        test_done();
    end
endmodule
